// >>> pkg/timer_pulse_defs.svh
`ifndef TIMER_PULSE_DEFS_SVH
`define TIMER_PULSE_DEFS_SVH

// register byte offsets, one aligned word each
`define OFS_COUNTER      8'h00
`define OFS_SYS_CTRL     8'h04
`define OFS_CTRL2        8'h08
`define OFS_WRAP_FLAG    8'h0c
`define OFS_FUNC_SEL     8'h10
`define OFS_DIRECTION    8'h14
`define OFS_ACC_CTRL     8'h18
`define OFS_ACC_FLAGS    8'h1c
`define OFS_ACC_COUNT    8'h20
`define OFS_TEST         8'h24
`define OFS_IRQ_STATUS   8'h28
`define OFS_CH7_OUT      8'h2c
`define OFS_CAP_TRIG     8'h30
`define OFS_CHAN_BASE    8'h40
`define OFS_CHAN_LAST    8'h5c

// system control fields
`define SYS_RUN_BIT      7
`define SYS_WAIT_BIT     6
`define SYS_DEBUG_BIT    5
`define SYS_FAST_BIT     4
// control 2 field
`define CTRL2_CLR7_BIT   3
// accumulator control fields
`define ACC_EN_BIT       6
`define ACC_MODE_BIT     5
`define ACC_EDGE_BIT     4
`define ACC_CLK_HI_BIT   3
`define ACC_CLK_LO_BIT   2
`define ACC_WRAP_IE_BIT  1
`define ACC_IN_IE_BIT    0
// accumulator flag fields
`define ACC_WRAP_F_BIT   1
`define ACC_IN_F_BIT     0
// test fields
`define TEST_CNT_BIT     1
`define TEST_ACC_BIT     0
// ch7 output fields
`define CH7_MODE_BIT     2
`define CH7_LEVEL_BIT    1
`define CH7_MASK_BIT     0

// timing
`define PRESCALE_DIV     16'd64
`define ALL_ONES16       16'hffff
`define RESET_BYTE       8'h00
`define RESET_WORD       16'h0000

`endif

// >>> pkg/timer_pulse_pkg.sv
package timer_pulse_pkg;

   // counter clock source choice
   typedef enum logic [1:0] {
      clk_prescale = 2'b00,
      clk_accum    = 2'b01,
      clk_acc_256  = 2'b10,
      clk_acc_64k  = 2'b11
   } clock_sel_t;

   // gated accumulator state
   typedef enum logic [1:0] {
      gate_idle = 2'b00,
      gate_open = 2'b01
   } gate_state_t;

   // wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   // interrupt request bundle
   typedef struct packed {
      logic counter_wrap;
      logic accum_wrap;
      logic accum_input;
   } irq_out_t;

endpackage

// >>> design/timer_pulse_accumulator.sv
`timescale 1ns/1ps
`include "timer_pulse_defs.svh"
module timer_pulse_accumulator
   import timer_pulse_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic [7:0]  chan_pin_i,
   output logic      [7:0]  chan_pin_oe,
   input  wire logic        special_mode_n,
   input  wire logic        debug_mode,
   input  wire logic        cpu_wait,
   output logic             counter_wrap_irq,
   output logic             accum_wrap_irq,
   output logic             accum_input_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [15:0] count_ff, nxt_count;
   logic [15:0] acc_ff, nxt_acc;
   logic [15:0] chan_ff [8];
   logic [15:0] nxt_chan [8];
   logic [5:0]  pre_ff, nxt_pre;
   logic [7:0]  acc_div_ff, nxt_acc_div;
   logic [7:0]  sys_ff, nxt_sys;
   logic [7:0]  ctrl2_ff, nxt_ctrl2;
   logic [7:0]  func_ff, nxt_func;
   logic [7:0]  dir_ff, nxt_dir;
   logic [7:0]  actl_ff, nxt_actl;
   logic [1:0]  aflg_ff, nxt_aflg;
   logic [1:0]  test_ff, nxt_test;
   logic [2:0]  ch7o_ff, nxt_ch7o;
   logic [15:0] edge_cfg_ff, nxt_edge_cfg;
   logic        wrap_ff, nxt_wrap;
   logic [7:0]  sw_trig;
   logic [7:0]  sync1_ff, sync2_ff, last_ff;
   logic [7:0]  oe_ff;
   logic        ack_ff, err_ff, nxt_ack, nxt_err;
   logic [31:0] rdat_ff, nxt_rdat;
   logic [2:0]  irq_ff;
   gate_state_t gate_ff, nxt_gate;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr == ofs);
   endfunction

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge8 = s[0] ? d[7:0] : old;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_ff <= `RESET_BYTE;
         sync2_ff <= `RESET_BYTE;
         last_ff  <= `RESET_BYTE;
      end else begin
         sync1_ff <= chan_pin_i;
         sync2_ff <= sync1_ff;
         last_ff  <= sync2_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enables and ticks
   logic       halted, timer_active, acc_on, acc_gated, edge_pol;
   logic       req, bus_ok, acc_run;
   logic       pre_tick, div64_tick, acc_event, gate_lvl, gate_trail, acc_clk;
   logic       count_tick, acc_tick, acc_div_wrap;
   clock_sel_t csel;

   always_comb begin
      halted       = sys_ff[`SYS_WAIT_BIT] & cpu_wait;
      timer_active = sys_ff[`SYS_RUN_BIT] & ~halted
                   & ~(sys_ff[`SYS_DEBUG_BIT] & debug_mode);
      acc_on       = actl_ff[`ACC_EN_BIT];
      acc_gated    = actl_ff[`ACC_MODE_BIT];
      edge_pol     = actl_ff[`ACC_EDGE_BIT];
      // event mode ignores the debug halt
      acc_run      = acc_on & ~halted;
      pre_tick     = timer_active & (test_ff[`TEST_CNT_BIT] | pre_ff == 6'h3f);
      div64_tick   = timer_active & (pre_ff == 6'h3f);
      // rising when polarity one, falling when zero
      acc_event    = edge_pol ? (sync2_ff[7] & ~last_ff[7]) : (~sync2_ff[7] & last_ff[7]);
      gate_lvl     = edge_pol ? ~sync2_ff[7] : sync2_ff[7];
      gate_trail   = (gate_ff == gate_open) & ~gate_lvl;
      acc_clk      = acc_gated ? (div64_tick & gate_lvl) : acc_event;
      acc_tick     = acc_run & (acc_clk | (test_ff[`TEST_ACC_BIT] & timer_active));
      acc_div_wrap = acc_tick & (acc_ff[7:0] == 8'hff);
      csel         = clock_sel_t'({actl_ff[`ACC_CLK_HI_BIT], actl_ff[`ACC_CLK_LO_BIT]});
      if (!acc_on)
         csel = clk_prescale;
      case (csel)
         clk_prescale: count_tick = pre_tick;
         clk_accum:    count_tick = acc_tick & timer_active;
         clk_acc_256:  count_tick = acc_div_wrap & timer_active;
         default:      count_tick = acc_div_wrap & (acc_ff[15:8] == 8'hff) & timer_active;
      endcase
      req    = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
      bus_ok = ~halted;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state: counters, flags, registers, bus
   logic [7:0] cap_evt;
   logic       wr, rd_or_wr;

   always_comb begin
      nxt_count    = count_ff;
      nxt_acc      = acc_ff;
      nxt_pre      = pre_ff;
      nxt_acc_div  = acc_div_ff;
      nxt_sys      = sys_ff;
      nxt_ctrl2    = ctrl2_ff;
      nxt_func     = func_ff;
      nxt_dir      = dir_ff;
      nxt_actl     = actl_ff;
      nxt_aflg     = aflg_ff;
      nxt_test     = test_ff;
      nxt_ch7o     = ch7o_ff;
      nxt_edge_cfg = edge_cfg_ff;
      nxt_wrap     = wrap_ff;
      nxt_gate     = gate_ff;
      nxt_ack      = 1'b0;
      nxt_err      = 1'b0;
      nxt_rdat     = 32'h0000_0000;
      sw_trig      = 8'h00;
      for (int i = 0; i < 8; i++)
         nxt_chan[i] = chan_ff[i];
      wr       = req & bus_ok & wb_we_i;
      rd_or_wr = req & bus_ok;

      // bus write and read decode
      if (req) begin
         nxt_ack = bus_ok;
         nxt_err = ~bus_ok;
         if (hit(wb_adr_i, `OFS_COUNTER)) begin
            nxt_rdat = {16'h0000, count_ff};
            if (wr & ~special_mode_n)
               nxt_count = merge16(count_ff, wb_dat_i, wb_sel_i);
         end else if (hit(wb_adr_i, `OFS_SYS_CTRL)) begin
            nxt_rdat = {24'h000000, sys_ff};
            if (wr)
               nxt_sys = merge8(sys_ff, wb_dat_i, wb_sel_i) & 8'hf0;
         end else if (hit(wb_adr_i, `OFS_CTRL2)) begin
            nxt_rdat = {24'h000000, ctrl2_ff};
            if (wr)
               nxt_ctrl2 = merge8(ctrl2_ff, wb_dat_i, wb_sel_i) & 8'h08;
         end else if (hit(wb_adr_i, `OFS_WRAP_FLAG)) begin
            nxt_rdat = {31'h0, wrap_ff};
         end else if (hit(wb_adr_i, `OFS_FUNC_SEL)) begin
            nxt_rdat = {24'h000000, func_ff};
            if (wr)
               nxt_func = merge8(func_ff, wb_dat_i, wb_sel_i);
         end else if (hit(wb_adr_i, `OFS_DIRECTION)) begin
            nxt_rdat = {24'h000000, dir_ff};
            if (wr)
               nxt_dir = merge8(dir_ff, wb_dat_i, wb_sel_i);
         end else if (hit(wb_adr_i, `OFS_ACC_CTRL)) begin
            nxt_rdat = {24'h000000, actl_ff};
            if (wr)
               nxt_actl = merge8(actl_ff, wb_dat_i, wb_sel_i) & 8'h7f;
         end else if (hit(wb_adr_i, `OFS_ACC_FLAGS)) begin
            nxt_rdat = {30'h0, aflg_ff};
         end else if (hit(wb_adr_i, `OFS_ACC_COUNT)) begin
            nxt_rdat = {16'h0000, acc_ff};
            if (wr)
               nxt_acc = merge16(acc_ff, wb_dat_i, wb_sel_i);
         end else if (hit(wb_adr_i, `OFS_TEST)) begin
            nxt_rdat = {30'h0, test_ff};
            if (wr & ~special_mode_n & wb_sel_i[0])
               nxt_test = wb_dat_i[1:0];
         end else if (hit(wb_adr_i, `OFS_IRQ_STATUS)) begin
            nxt_rdat = {29'h0, irq_ff};
         end else if (hit(wb_adr_i, `OFS_CH7_OUT)) begin
            nxt_rdat = {29'h0, ch7o_ff};
            if (wr & wb_sel_i[0])
               nxt_ch7o = wb_dat_i[2:0];
         end else if (hit(wb_adr_i, `OFS_CAP_TRIG)) begin
            nxt_rdat = {16'h0000, edge_cfg_ff};
            if (wr) begin
               nxt_edge_cfg = merge16(edge_cfg_ff, wb_dat_i, wb_sel_i);
               if (wb_sel_i[2])
                  sw_trig = wb_dat_i[23:16] & ~func_ff & dir_ff;
            end
         end else if (wb_adr_i >= `OFS_CHAN_BASE && wb_adr_i <= `OFS_CHAN_LAST
                      && wb_adr_i[1:0] == 2'b00) begin
            nxt_rdat = {16'h0000, chan_ff[wb_adr_i[4:2]]};
            if (wr & func_ff[wb_adr_i[4:2]])
               nxt_chan[wb_adr_i[4:2]] = merge16(chan_ff[wb_adr_i[4:2]], wb_dat_i,
                                                 wb_sel_i);
         end else begin
            nxt_ack = 1'b0;
            nxt_err = 1'b1;
         end
      end

      // free-running counter with channel 7 clear and split test mode
      if (count_tick && !(wr && hit(wb_adr_i, `OFS_COUNTER))) begin
         if (test_ff[`TEST_CNT_BIT])
            nxt_count = {count_ff[15:8] + 8'h01, count_ff[7:0] + 8'h01};
         else if (ctrl2_ff[`CTRL2_CLR7_BIT] && func_ff[7] && count_ff == chan_ff[7])
            nxt_count = `RESET_WORD;
         else
            nxt_count = count_ff + 16'h0001;
      end
      if (timer_active)
         nxt_pre = test_ff[`TEST_CNT_BIT] ? 6'h00 : pre_ff + 6'h01;
      nxt_acc_div = acc_div_ff;

      // accumulator count
      if (acc_tick && !(wr && hit(wb_adr_i, `OFS_ACC_COUNT))) begin
         if (test_ff[`TEST_ACC_BIT])
            nxt_acc = {acc_ff[15:8] + 8'h01, acc_ff[7:0] + 8'h01};
         else
            nxt_acc = acc_ff + 16'h0001;
      end

      // gate tracking for gated mode
      if (acc_run && acc_gated)
         nxt_gate = gate_lvl ? gate_open : gate_idle;
      else
         nxt_gate = gate_idle;

      // wrap flag: clear first, set wins
      if (wr && hit(wb_adr_i, `OFS_WRAP_FLAG) && wb_sel_i[0] && wb_dat_i[0])
         nxt_wrap = 1'b0;
      if (rd_or_wr && sys_ff[`SYS_FAST_BIT] && hit(wb_adr_i, `OFS_COUNTER))
         nxt_wrap = 1'b0;
      if (count_tick && count_ff == `ALL_ONES16 && !test_ff[`TEST_CNT_BIT]
          && !(ctrl2_ff[`CTRL2_CLR7_BIT] && func_ff[7] && chan_ff[7] == `ALL_ONES16))
         nxt_wrap = 1'b1;

      // accumulator flags: clear first, set wins
      if (wr && hit(wb_adr_i, `OFS_ACC_FLAGS) && wb_sel_i[0])
         nxt_aflg = aflg_ff & ~wb_dat_i[1:0];
      if (rd_or_wr && sys_ff[`SYS_FAST_BIT] && hit(wb_adr_i, `OFS_ACC_COUNT))
         nxt_aflg = 2'b00;
      if (acc_tick && acc_ff == `ALL_ONES16)
         nxt_aflg[`ACC_WRAP_F_BIT] = 1'b1;
      if (acc_run && (acc_gated ? gate_trail : acc_event))
         nxt_aflg[`ACC_IN_F_BIT] = 1'b1;

      // input capture on pin edges or software trigger
      for (int i = 0; i < 8; i++) begin
         cap_evt[i] = ~func_ff[i] & timer_active
                    & (sw_trig[i] | (~dir_ff[i]
                    & ((edge_cfg_ff[2*i] & sync2_ff[i] & ~last_ff[i])
                    | (edge_cfg_ff[2*i+1] & ~sync2_ff[i] & last_ff[i]))));
         if (cap_evt[i])
            nxt_chan[i] = count_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_ff    <= `RESET_WORD;
         acc_ff      <= `RESET_WORD;
         pre_ff      <= 6'h00;
         acc_div_ff  <= `RESET_BYTE;
         sys_ff      <= `RESET_BYTE;
         ctrl2_ff    <= `RESET_BYTE;
         func_ff     <= `RESET_BYTE;
         dir_ff      <= `RESET_BYTE;
         actl_ff     <= `RESET_BYTE;
         aflg_ff     <= 2'b00;
         test_ff     <= 2'b00;
         ch7o_ff     <= 3'h0;
         edge_cfg_ff <= `RESET_WORD;
         wrap_ff     <= 1'b0;
         gate_ff     <= gate_idle;
         ack_ff      <= 1'b0;
         err_ff      <= 1'b0;
         rdat_ff     <= 32'h0000_0000;
         for (int i = 0; i < 8; i++)
            chan_ff[i] <= `RESET_WORD;
      end else begin
         count_ff    <= nxt_count;
         acc_ff      <= nxt_acc;
         pre_ff      <= nxt_pre;
         acc_div_ff  <= nxt_acc_div;
         sys_ff      <= nxt_sys;
         ctrl2_ff    <= nxt_ctrl2;
         func_ff     <= nxt_func;
         dir_ff      <= nxt_dir;
         actl_ff     <= nxt_actl;
         aflg_ff     <= nxt_aflg;
         test_ff     <= nxt_test;
         ch7o_ff     <= nxt_ch7o;
         edge_cfg_ff <= nxt_edge_cfg;
         wrap_ff     <= nxt_wrap;
         gate_ff     <= nxt_gate;
         ack_ff      <= nxt_ack;
         err_ff      <= nxt_err;
         rdat_ff     <= nxt_rdat;
         for (int i = 0; i < 8; i++)
            chan_ff[i] <= nxt_chan[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin direction and interrupt outputs, registered
   logic [7:0] nxt_oe;
   logic [2:0] nxt_irq;

   always_comb begin
      nxt_oe     = func_ff | dir_ff;
      // shared accumulator pin released only when ch7 output use is off
      nxt_oe[7]  = (func_ff[7] & (ch7o_ff[`CH7_MODE_BIT] | ch7o_ff[`CH7_LEVEL_BIT]
                   | ch7o_ff[`CH7_MASK_BIT])) | dir_ff[7];
      nxt_irq[2] = wrap_ff & 1'b0;
      nxt_irq[1] = aflg_ff[`ACC_WRAP_F_BIT] & actl_ff[`ACC_WRAP_IE_BIT];
      nxt_irq[0] = aflg_ff[`ACC_IN_F_BIT] & actl_ff[`ACC_IN_IE_BIT];
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         oe_ff  <= `RESET_BYTE;
         irq_ff <= 3'h0;
      end else begin
         oe_ff  <= nxt_oe;
         irq_ff <= nxt_irq;
      end
   end

   always_comb begin
      wb_dat_o         = rdat_ff;
      wb_ack_o         = ack_ff;
      wb_err_o         = err_ff;
      chan_pin_oe      = oe_ff;
      counter_wrap_irq = irq_ff[2];
      accum_wrap_irq   = irq_ff[1];
      accum_input_irq  = irq_ff[0];
   end

endmodule // timer_pulse_accumulator

// >>> verif/timer_pulse_sva.sv
`timescale 1ns/1ps
`include "timer_pulse_defs.svh"
module timer_pulse_sva
   import timer_pulse_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic [7:0]  chan_pin_i,
   input wire logic [7:0]  chan_pin_oe,
   input wire logic        special_mode_n,
   input wire logic        debug_mode,
   input wire logic        cpu_wait,
   input wire logic        counter_wrap_irq,
   input wire logic        accum_wrap_irq,
   input wire logic        accum_input_irq
);
   logic       taken;
   logic [7:0] fsel_ff, dir_ff, acc_ff, nxt_fsel, nxt_dir, nxt_acc;
   logic       halt_ff, nxt_halt;

   ////////////////////////////////////////////////////////////////////////////
   // shadow of accepted register writes
   assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   always_comb begin
      nxt_fsel = fsel_ff;
      nxt_dir  = dir_ff;
      nxt_acc  = acc_ff;
      nxt_halt = halt_ff;
      if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            `OFS_FUNC_SEL:  nxt_fsel = wb_dat_i[7:0];
            `OFS_DIRECTION: nxt_dir = wb_dat_i[7:0];
            `OFS_ACC_CTRL:  nxt_acc = wb_dat_i[7:0];
            `OFS_SYS_CTRL:  nxt_halt = wb_dat_i[`SYS_WAIT_BIT];
            default:        nxt_halt = halt_ff;
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fsel_ff <= 8'h00;
         dir_ff  <= 8'h00;
         acc_ff  <= 8'h00;
         halt_ff <= 1'b0;
      end else begin
         fsel_ff <= nxt_fsel;
         dir_ff  <= nxt_dir;
         acc_ff  <= nxt_acc;
         halt_ff <= nxt_halt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // one answer, then quiet
   sequence s_answer;
      (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
   endsequence
   a_answer_single: assert property (taken |=> s_answer)
      else $error("bus answer missing or longer than one cycle");
   a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !(wb_ack_o || wb_err_o))
      else $error("answer without request");
   a_unmapped_err: assert property (taken && (wb_adr_i == 8'h34 || wb_adr_i > 8'h5c)
      |=> wb_err_o)
      else $error("unmapped access not refused");
   a_wait_refuse: assert property (taken && cpu_wait && halt_ff |=> wb_err_o && !wb_ack_o)
      else $error("access accepted during wait halt");
   a_wrap_irq_mask: assert property (!acc_ff[`ACC_WRAP_IE_BIT] |-> !accum_wrap_irq)
      else $error("wrap irq while disabled");
   a_input_irq_mask: assert property (!acc_ff[`ACC_IN_IE_BIT] |-> !accum_input_irq)
      else $error("input irq while disabled");
   a_counter_irq_idle: assert property (!counter_wrap_irq)
      else $error("counter irq raised");
   a_pin_drive: assert property ($stable(fsel_ff) && $stable(dir_ff)
      |-> chan_pin_oe[6:0] == (fsel_ff[6:0] | dir_ff[6:0]))
      else $error("pin direction wrong");
endmodule // timer_pulse_sva

bind timer_pulse_accumulator timer_pulse_sva sva_u (
   .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .chan_pin_i(chan_pin_i), .chan_pin_oe(chan_pin_oe), .special_mode_n(special_mode_n),
   .debug_mode(debug_mode), .cpu_wait(cpu_wait), .counter_wrap_irq(counter_wrap_irq),
   .accum_wrap_irq(accum_wrap_irq), .accum_input_irq(accum_input_irq));

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "timer_pulse_defs.svh"
module testbench
   import timer_pulse_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   wb_req_t     req = '0;
   logic [7:0]  pins = 8'h00;
   logic        special_mode_n = 1'b1;
   logic        cpu_wait = 1'b0;
   logic        debug_mode = 1'b0;
   logic [31:0] wb_dat_o, q;
   logic        wb_ack_o, wb_err_o, e, irq_c, irq_w, irq_i;
   logic [7:0]  oe;
   int          num_errors = 0;
   int          num_checks = 0;

   ////////////////////////////////////////////////////////////////////////////
   always #5 ref_clk = ~ref_clk;
   timer_pulse_accumulator dut_u (
      .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
      .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .chan_pin_i(pins), .chan_pin_oe(oe), .special_mode_n(special_mode_n),
      .debug_mode(debug_mode), .cpu_wait(cpu_wait), .counter_wrap_irq(irq_c),
      .accum_wrap_irq(irq_w), .accum_input_irq(irq_i));

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle, compare and pin helpers
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 20);
      q = wb_dat_o;
      e = wb_err_o;
      if (n >= 20) begin
         $display("[FAIL] bus answer exp ack got none");
         num_errors++;
      end
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         $display("[FAIL] %s exp %h got %h", s, x, g);
         num_errors++;
      end
   endtask
   task automatic pin_set(input int b, input logic v);
      pins[b] <= v;
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic gate_low();
      pins[7] <= 1'b0;
      repeat (640) @(posedge ref_clk);
      pin_set(7, 1'b1);
   endtask
   task automatic wait_wrap();
      wr(`OFS_COUNTER, 32'hfffe);
      for (int n = 0; n < 300; n++) begin
         rd(`OFS_WRAP_FLAG);
         if (q[0] === 1'b1) break;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      logic [7:0] ofs [4] = '{`OFS_ACC_CTRL, `OFS_ACC_FLAGS, `OFS_ACC_COUNT, `OFS_DIRECTION};
      foreach (ofs[i]) begin
         rd(ofs[i]);
         chk("reset value", 32'h0, q & 32'hffff);
      end
      rd(8'h34);
      chk("unmapped err", 32'h1, {31'h0, e});
   endtask
   task automatic t_event();
      for (int p = 0; p < 2; p++) begin
         wr(`OFS_ACC_CTRL, 32'h40 | 32'(p << 4));
         wr(`OFS_ACC_COUNT, 32'hfffe);
         wr(`OFS_ACC_FLAGS, 32'h3);
         repeat (2) begin
            pin_set(7, 1'b1);
            pin_set(7, 1'b0);
         end
         rd(`OFS_ACC_COUNT);
         chk("event count", 32'h0, q & 32'hffff);
         rd(`OFS_ACC_FLAGS);
         chk("event flags", 32'h3, q & 32'h3);
      end
      wr(`OFS_ACC_CTRL, 32'h42);
      repeat (3) @(posedge ref_clk);
      chk("wrap irq", 32'h1, {31'h0, irq_w});
      chk("input irq", 32'h0, {31'h0, irq_i});
      wr(`OFS_ACC_FLAGS, 32'h0);
      rd(`OFS_ACC_FLAGS);
      chk("flags kept", 32'h3, q & 32'h3);
      wr(`OFS_ACC_FLAGS, 32'h2);
      rd(`OFS_ACC_FLAGS);
      chk("wrap cleared", 32'h1, q & 32'h3);
      wr(`OFS_SYS_CTRL, 32'h10);
      rd(`OFS_ACC_COUNT);
      rd(`OFS_ACC_FLAGS);
      chk("fast clear acc", 32'h0, q & 32'h3);
   endtask
   task automatic t_counter();
      special_mode_n <= 1'b0;
      wr(`OFS_SYS_CTRL, 32'h80);
      wait_wrap();
      chk("wrap set", 32'h1, q & 32'h1);
      wr(`OFS_WRAP_FLAG, 32'h1);
      rd(`OFS_WRAP_FLAG);
      chk("wrap w1c", 32'h0, q & 32'h1);
      wr(`OFS_SYS_CTRL, 32'h90);
      wait_wrap();
      rd(`OFS_COUNTER);
      rd(`OFS_WRAP_FLAG);
      chk("fast clear cnt", 32'h0, q & 32'h1);
      wr(`OFS_SYS_CTRL, 32'h80);
      wr(`OFS_FUNC_SEL, 32'h80);
      wr(`OFS_CHAN_LAST, 32'hffff);
      wr(`OFS_CTRL2, 32'h08);
      wr(`OFS_COUNTER, 32'hfffe);
      wr(`OFS_WRAP_FLAG, 32'h1);
      for (int n = 0; n < 300; n++) begin
         rd(`OFS_COUNTER);
         if (q[15:0] < 16'h0100) break;
      end
      rd(`OFS_WRAP_FLAG);
      chk("ch7 clear no wrap", 32'h0, q & 32'h1);
      rd(`OFS_CHAN_LAST);
      chk("compare readback", 32'hffff, q & 32'hffff);
      wr(`OFS_CTRL2, 32'h0);
      special_mode_n <= 1'b1;
      wr(`OFS_TEST, 32'h3);
      rd(`OFS_TEST);
      chk("test locked", 32'h0, q & 32'h3);
      special_mode_n <= 1'b0;
      wr(`OFS_TEST, 32'h1);
      rd(`OFS_TEST);
      chk("test open", 32'h1, q & 32'h3);
      wr(`OFS_TEST, 32'h0);
   endtask
   task automatic t_capture();
      logic [31:0] p;
      wr(`OFS_SYS_CTRL, 32'h0);
      wr(`OFS_COUNTER, 32'h0abc);
      wr(`OFS_FUNC_SEL, 32'h02);
      wr(`OFS_CAP_TRIG, 32'h1);
      rd(`OFS_CHAN_BASE);
      p = q;
      wr(`OFS_CHAN_BASE, 32'h5555);
      rd(`OFS_CHAN_BASE);
      chk("capture no write", p, q);
      wr(8'h44, 32'h5a5a);
      rd(8'h44);
      chk("compare write", 32'h5a5a, q & 32'hffff);
      // captures need a running timer: sync to a prescaler tick first
      wr(`OFS_DIRECTION, 32'h04);
      wr(`OFS_SYS_CTRL, 32'h80);
      rd(`OFS_COUNTER);
      p = q;
      do rd(`OFS_COUNTER); while (q == p);
      wr(`OFS_COUNTER, 32'h0abc);
      pin_set(0, 1'b1);
      wr(`OFS_CAP_TRIG, 32'h0004_0001);
      wr(`OFS_SYS_CTRL, 32'h0);
      rd(`OFS_CHAN_BASE);
      chk("pin capture", 32'h0abc, q & 32'hffff);
      rd(8'h48);
      chk("soft capture", 32'h0abc, q & 32'hffff);
      chk("pin enables", 32'h06, {24'h0, oe});
   endtask
   task automatic t_gated();
      pin_set(7, 1'b1);
      wr(`OFS_ACC_CTRL, 32'h70);
      wr(`OFS_ACC_COUNT, 32'h0);
      gate_low();
      rd(`OFS_ACC_COUNT);
      chk("no tick stopped", 32'h0, q & 32'hffff);
      wr(`OFS_SYS_CTRL, 32'h80);
      wr(`OFS_ACC_FLAGS, 32'h3);
      gate_low();
      rd(`OFS_ACC_COUNT);
      chk("gated ticks", 32'h1, {31'h0, q[15:0] inside {[16'd9:16'd11]}});
      rd(`OFS_ACC_FLAGS);
      chk("trailing flag", 32'h1, q & 32'h1);
   endtask
   task automatic t_wait();
      // debug halt freezes the counter, event counting goes on
      wr(`OFS_SYS_CTRL, 32'ha0);
      wr(`OFS_ACC_CTRL, 32'h50);
      wr(`OFS_ACC_COUNT, 32'h0);
      debug_mode <= 1'b1;
      wr(`OFS_COUNTER, 32'h1234);
      pin_set(7, 1'b0);
      pin_set(7, 1'b1);
      repeat (70) @(posedge ref_clk);
      rd(`OFS_COUNTER);
      chk("debug stops counter", 32'h1234, q & 32'hffff);
      rd(`OFS_ACC_COUNT);
      chk("debug keeps events", 32'h1, q & 32'hffff);
      debug_mode <= 1'b0;
      wr(`OFS_SYS_CTRL, 32'h40);
      cpu_wait <= 1'b1;
      rd(`OFS_ACC_CTRL);
      chk("wait refuses", 32'h1, {31'h0, e});
      cpu_wait <= 1'b0;
      rd(`OFS_SYS_CTRL);
      chk("enables kept", 32'h40, q & 32'hff);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict, sequence and watchdog
   task automatic report_and_stop();
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_event();
      t_counter();
      t_capture();
      t_gated();
      t_wait();
      report_and_stop();
   end
   initial begin
      repeat (50000) @(posedge ref_clk);
      $display("[FAIL] watchdog exp done got hang");
      num_errors++;
      report_and_stop();
   end
endmodule // testbench
